// ===== verilog/oscfc_top.sv
// Overview of operation
// RULE1: Overtemperature and overcurrent faults set the output's status bit.
// RULE2: Open load while an output is on is never reported.
// RULE3: Off-state open load reports only when that output's detect current is on.
// RULE4: Battery overvoltage turns all outputs off; commanded state returns after.
// RULE5: Overtemperature shuts only that output; it restarts unless since commanded off.
// RULE6: Sleep or logic supply loss resets everything: outputs off, currents off. Code clears only command and status registers.
// RULE7: Controller lowers inputs and commands outputs off before sleep.
// RULE8: Status word shifts out while the command word shifts in.
// RULE9: No faults with currents enabled means all status bits read zero.
// RULE10: Controller classifies faults using the previous command bit.
// RULE11: Controller spaces command writes more than 300 us apart.
// RULE12: First 16 returned bits are eight zeros then eight status bits.
// RULE13: In longer frames later returned bits echo the bits sent earlier.
// RULE14: Last 16 bits before select rises become the command on that edge.
// RULE15: Only frames of 16 plus a multiple of 8 clocks are accepted.
// RULE16: Each output has its own open-load indication, used only while off.
// RULE17: Detect current follows its command bit, off at reset and in sleep.
// RULE18: Select rise starts a fault filter; open-load input ignored until expiry.
// RULE19: Open-load faults stay latched until read out.
// RULE20: Thermal limit turns an output off until cooled, then it retries.
// RULE21: Short faults report regardless of detect current enables.
// RULE22: Undervoltage turns all outputs off; recovery resets the logic.
// RULE23: Command bits 0 to 7 switch outputs 1 to 8.
// RULE24: Command bits 8 to 15 enable detect currents of outputs 1 to 8.
// RULE25: Frames shift most significant bit first both ways.
// RULE26: Direct drive inputs five and six are ORed with their command bits.
// RULE27: Status is loaded into the shift register when select falls.
`timescale 1ns/1ps
module oscfc_top
  import oscfc_pkg::*;
#(
  parameter int unsigned FILTER_COUNT = FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wake,
  input wire logic logic_supply_ok,
  input wire logic battery_supply_uv,
  input wire logic battery_supply_ov,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  input wire logic direct_drive_input_five,
  input wire logic direct_drive_input_six,
  input wire logic [NUM_OUT-1:0] thermal_limit,
  input wire logic [NUM_OUT-1:0] overcurrent,
  input wire logic [NUM_OUT-1:0] open_load_cmp,
  output logic [NUM_OUT-1:0] out_on,
  output logic [NUM_OUT-1:0] detect_current_on
);
  import oscfc_pkg::*;

  // ****************************************
  // Reset and sleep
  // ****************************************
  logic rst_meta_q;
  logic rst_q;
  logic rst_n;
  logic [8:0] sync_in;
  logic [8:0] sync_out;
  logic sclk_s;
  logic cs_act_s;
  logic cs_n_s;
  logic sdi_s;
  logic wake_s;
  logic vdd_s;
  logic uv_s;
  logic ov_s;
  logic dd5_s;
  logic dd6_s;
  logic [NUM_OUT-1:0] thermal_limit_s;
  logic [NUM_OUT-1:0] oc_s;
  logic [NUM_OUT-1:0] olc_s;
  logic sleep_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_q;

  // Select crosses inverted so the cleared synchroniser reads as idle;
  // otherwise a false frame would open as reset lets go
  assign sync_in = {sclk, ~cs_n, sdi, wake, logic_supply_ok, battery_supply_uv,
    battery_supply_ov, direct_drive_input_five, direct_drive_input_six};

  oscfc_sync #(.W(9)) u_sync_ctl (
    .clk(clk),
    .rst_n(rst_n),
    .d(sync_in),
    .q(sync_out)
  );

  oscfc_sync #(.W(3 * NUM_OUT)) u_sync_flt (
    .clk(clk),
    .rst_n(rst_n),
    .d({thermal_limit, overcurrent, open_load_cmp}),
    .q({thermal_limit_s, oc_s, olc_s})
  );

  assign {sclk_s, cs_act_s, sdi_s, wake_s, vdd_s, uv_s, ov_s, dd5_s, dd6_s} = sync_out;
  assign cs_n_s = ~cs_act_s;

  // Sleep and undervoltage both act as a synchronous logic reset
  assign sleep_n = wake_s & vdd_s & !uv_s; // see RULE6 see RULE22

  // ****************************************
  // Link edge detection
  // ****************************************
  logic sclk_d_q;
  logic cs_n_d_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  oscfc_link_t link_q;
  oscfc_link_t link_d;

  // Edge decode shared by link clock and select
  function automatic logic went_high(input logic now_v, input logic was_v);
    went_high = now_v & !was_v;
  endfunction : went_high

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
      cs_n_d_q <= cs_n_s;
    end
  end

  assign sclk_rise = went_high(sclk_s, sclk_d_q) & !cs_n_s;
  assign sclk_fall = went_high(sclk_d_q, sclk_s) & !cs_n_s;
  assign cs_fall = went_high(cs_n_d_q, cs_n_s);
  assign cs_rise = went_high(cs_n_s, cs_n_d_q);

  // Frame state only tracks select; link clock edges outside it are ignored
  always_comb begin
    link_d = link_q;
    case (link_q)
      OSCFC_IDLE: if (cs_fall) link_d = OSCFC_FRAME;
      OSCFC_FRAME: if (cs_rise) link_d = OSCFC_IDLE;
      default: link_d = OSCFC_IDLE;
    endcase
  end

  // ****************************************
  // Shift register and pulse count
  // ****************************************
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] shift_d;
  logic [FRAME_BITS-1:0] cmd_q;
  logic [7:0] pulse_q;
  logic [7:0] pulse_d;
  logic sdo_q;
  logic sdo_d;
  logic [NUM_OUT-1:0] status_q;
  logic [NUM_OUT-1:0] status_d;
  logic frame_ok;

  function automatic logic count_ok(input logic [7:0] n);
    count_ok = (n >= BASE_PULSES) && ((n & {5'h00, BYTE_MASK}) == 8'h00);
  endfunction : count_ok

  // Counter saturates so very long frames cannot wrap into a legal count
  assign frame_ok = count_ok(pulse_q) && (pulse_q != 8'hff); // see RULE15

  always_comb begin
    shift_d = shift_q;
    pulse_d = pulse_q;
    sdo_d = sdo_q;
    if (cs_fall) begin
      // Status is frozen into the frame before the first link clock edge
      shift_d = {STATUS_PAD, status_q}; // see RULE27 see RULE12 see RULE8
      sdo_d = STATUS_PAD[7];
      pulse_d = 8'h00;
    end else if (link_q == OSCFC_FRAME) begin
      if (sclk_rise) begin
        shift_d = {shift_q[FRAME_BITS-2:0], sdi_s}; // see RULE25 see RULE13
        if (pulse_q != 8'hff) begin
          pulse_d = pulse_q + 8'h01;
        end
      end
      // Next bit leaves on the falling edge so it is settled at the master's rise
      if (sclk_fall) begin
        sdo_d = shift_q[FRAME_BITS-1]; // see RULE25
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= OSCFC_IDLE;
      shift_q <= CMD_RESET;
      pulse_q <= 8'h00;
      sdo_q <= 1'b0;
    end else begin
      link_q <= link_d;
      shift_q <= shift_d;
      pulse_q <= pulse_d;
      sdo_q <= sdo_d;
    end
  end

  assign sdo = sdo_q;

  // ****************************************
  // Command latch
  // ****************************************
  // Rejected frames leave the command as it was; status still reloads next frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= CMD_RESET;
    end else if (!sleep_n) begin
      cmd_q <= CMD_RESET; // see RULE6 see RULE17
    end else if (cs_rise && link_q == OSCFC_FRAME && frame_ok) begin
      cmd_q <= shift_q; // see RULE14 see RULE15
    end
  end

  // ****************************************
  // Fault filter timer
  // ****************************************
  // Counts down from each select rise; open-load sensing waits for zero
  logic [FILTER_W-1:0] filt_q;
  logic [FILTER_W-1:0] filt_d;
  logic filt_done;

  assign filt_done = (filt_q == '0);

  always_comb begin
    filt_d = filt_q;
    if (cs_rise) begin
      filt_d = FILTER_W'(FILTER_COUNT); // see RULE18
    end else if (!filt_done) begin
      filt_d = filt_q - FILTER_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt_d;
    end
  end

  // ****************************************
  // Fault status and output drive
  // ****************************************
  logic [NUM_OUT-1:0] cmd_out;
  logic [NUM_OUT-1:0] cmd_old;
  logic [NUM_OUT-1:0] want_on;
  logic [NUM_OUT-1:0] open_flt;
  logic [NUM_OUT-1:0] short_flt;

  assign cmd_out = cmd_q[CMD_OUT_LSB +: NUM_OUT]; // see RULE23
  assign cmd_old = cmd_q[CMD_OLD_LSB +: NUM_OUT]; // see RULE24

  // Direct drive only ever adds on-time to outputs five and six
  always_comb begin
    want_on = cmd_out;
    want_on[OUT_FIVE] = cmd_out[OUT_FIVE] | dd5_s; // see RULE26
    want_on[OUT_SIX] = cmd_out[OUT_SIX] | dd6_s; // see RULE26
  end

  // Open load only counts when off, current on and filter elapsed
  assign open_flt = olc_s & ~want_on & cmd_old // see RULE2 see RULE3 see RULE16
    & {NUM_OUT{filt_done}}; // see RULE18
  assign short_flt = thermal_limit_s | oc_s; // see RULE1 see RULE21

  // Set wins over the clear at frame start so no event is lost
  always_comb begin
    status_d = status_q;
    if (cs_fall) begin
      status_d = STATUS_RESET;
    end
    status_d = status_d | open_flt | short_flt; // see RULE19 see RULE9
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_RESET;
    end else if (!sleep_n) begin
      // Sleep drops latched faults together with the command
      status_q <= STATUS_RESET; // see RULE6
    end else begin
      status_q <= status_d;
    end
  end

  // Thermal shutdown is per output and recovers without software help
  assign out_on = want_on & ~thermal_limit_s // see RULE5 see RULE20
    & {NUM_OUT{!ov_s && sleep_n}}; // see RULE4 see RULE22
  assign detect_current_on = cmd_old & {NUM_OUT{sleep_n}}; // see RULE17

endmodule : oscfc_top

// ===== verilog/oscfc_pkg.sv
package oscfc_pkg;

  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned NUM_OUT = 8;
  localparam logic [7:0] BASE_PULSES = 8'h10;
  localparam logic [2:0] BYTE_MASK = 3'h7;
  localparam int unsigned CMD_OUT_LSB = 0;
  localparam int unsigned CMD_OLD_LSB = 8;
  localparam int unsigned OUT_FIVE = 4;
  localparam int unsigned OUT_SIX = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_PAD = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned FILTER_TIME_US = 100;
  localparam int unsigned FILTER_CYCLES = (FILTER_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int unsigned FILTER_W = 16;

  typedef enum logic [1:0] {
    OSCFC_IDLE = 2'b00,
    OSCFC_FRAME = 2'b01
  } oscfc_link_t;

endpackage : oscfc_pkg

// ===== verilog/oscfc_sync.sv
`timescale 1ns/1ps
module oscfc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // ****************************************
  // Two-flop synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : oscfc_sync

// ===== tb/oscfc_monitor.sv
`timescale 1ns/1ps
module oscfc_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wake,
  input wire logic logic_supply_ok,
  input wire logic battery_supply_uv,
  input wire logic battery_supply_ov,
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic [7:0] thermal_limit,
  input wire logic [7:0] out_on,
  input wire logic [7:0] detect_current_on
);
  // ****************************************
  // Checks; six cycles cover input sync plus the register
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_frame_open;
    $fell(cs_n) ##1 !cs_n [*5];
  endsequence
  sequence s_awake_frame;
    (!cs_n && wake && logic_supply_ok && !battery_supply_uv) [*8];
  endsequence
  a_sleep_out_off: assert property (!wake [*6] |-> out_on == 8'h00)
    else $error("outputs on in sleep");
  a_sleep_detect_off: assert property (!wake [*6] |-> detect_current_on == 8'h00)
    else $error("detect current on in sleep");
  a_supply_loss_off: assert property (!logic_supply_ok [*6] |->
    out_on == 8'h00 && detect_current_on == 8'h00)
    else $error("outputs on without logic supply");
  a_ov_all_off: assert property (battery_supply_ov [*6] |-> out_on == 8'h00)
    else $error("outputs on in overvoltage");
  a_uv_all_off: assert property (battery_supply_uv [*6] |-> out_on == 8'h00)
    else $error("outputs on in undervoltage");
  a_thermal_out_off: assert property ((thermal_limit & $past(thermal_limit, 2)
    & $past(thermal_limit, 4) & out_on) == 8'h00)
    else $error("output on at thermal limit");
  a_frame_cmd_hold: assert property (s_awake_frame |-> $stable(detect_current_on))
    else $error("command changed inside frame");
  a_pad_first_zero: assert property (s_frame_open |-> !sdo)
    else $error("first status bit not zero");
endmodule : oscfc_monitor

bind oscfc_top oscfc_monitor u_mon (.clk, .resetn, .wake, .logic_supply_ok,
  .battery_supply_uv, .battery_supply_ov, .cs_n, .sdo, .thermal_limit, .out_on,
  .detect_current_on);

// ===== tb/oscfc_spi_master.sv
`timescale 1ns/1ps
module oscfc_spi_master #(
  parameter int GAP_NS = 250
) (
  output logic sclk = 1'b0,
  output logic cs_n = 1'b1,
  output logic sdi = 1'b0,
  input wire logic sdo
);
  // ****************************************
  // Frame of n pulses on a 48 ns link clock
  // ****************************************
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #24 sclk = 1'b1;
      rx = {rx[30:0], sdo};
      #24 sclk = 1'b0;
    end
    #24 cs_n = 1'b1;
    // Unselected data line must not keep a stale bit
    sdi = ~sdi;
    // Spacing scaled with the shortened filter count
    #GAP_NS;
  endtask : xfer
endmodule : oscfc_spi_master

// ===== tb/octal_switch_spi_fault_control_tb_top.sv
`timescale 1ns/1ps
module octal_switch_spi_fault_control_tb_top;
  logic clk, resetn, wake, logic_supply_ok, battery_supply_uv, battery_supply_ov;
  logic sclk, cs_n, sdi, sdo, drive_five, drive_six;
  logic [7:0] thermal, overcurrent, open_load, out_on, detect;
  logic [31:0] rx;
  int mismatches = 0;
  int n_checks = 0;
  oscfc_top #(.FILTER_COUNT(20)) dut (.clk, .resetn, .wake, .logic_supply_ok,
    .battery_supply_uv, .battery_supply_ov, .sclk, .cs_n, .sdi, .sdo,
    .direct_drive_input_five(drive_five), .direct_drive_input_six(drive_six),
    .thermal_limit(thermal), .overcurrent(overcurrent), .open_load_cmp(open_load),
    .out_on(out_on), .detect_current_on(detect));
  oscfc_spi_master m (.sclk, .cs_n, .sdi, .sdo);
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk
  task automatic send(input int n, input logic [31:0] tx);
    @(negedge clk);
    m.xfer(n, tx, rx);
    @(negedge clk);
  endtask : send
  task automatic settle(input int c);
    repeat (c) @(negedge clk);
  endtask : settle
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_command;
    send(16, 32'h0000a55a);
    chk("out_on", 16'h5a, 16'(out_on));
    chk("detect", 16'ha5, 16'(detect));
    send(32, 32'h123400f0);
    chk("pad", 16'h0000, rx[31:16]);
    chk("echo", 16'h1234, rx[15:0]);
    chk("out_32", 16'hf0, 16'(out_on));
  endtask : t_command
  task automatic t_count;
    send(15, 32'h00007fff);
    send(17, 32'h0001ffff);
    chk("bad_count", 16'hf0, 16'(out_on));
    send(24, 32'h00ff0003);
    chk("out_24", 16'h03, 16'(out_on));
  endtask : t_count
  task automatic t_fault;
    send(16, 32'h02c4);
    open_load = 8'h0f;
    overcurrent = 8'h40;
    thermal = 8'h80;
    settle(40);
    chk("thermal_off", 16'h44, 16'(out_on));
    open_load = 8'h00;
    overcurrent = 8'h00;
    thermal = 8'h00;
    settle(10);
    chk("resume", 16'hc4, 16'(out_on));
    send(16, 32'h0);
    chk("status", 16'h00c2, rx[15:0]);
    chk("short_class", 16'h00c0, rx[15:0] & 16'h00c4);
    chk("open_class", 16'h0002, rx[15:0] & ~16'h00c4);
    send(16, 32'h0);
    chk("cleared", 16'h0, rx[15:0]);
  endtask : t_fault
  task automatic t_supply;
    send(16, 32'h000f);
    battery_supply_ov = 1'b1;
    settle(10);
    chk("ov_off", 16'h0, 16'(out_on));
    battery_supply_ov = 1'b0;
    settle(10);
    chk("ov_back", 16'h0f, 16'(out_on));
    drive_five = 1'b1;
    drive_six = 1'b1;
    settle(10);
    chk("direct", 16'h3f, 16'(out_on));
    drive_five = 1'b0;
    drive_six = 1'b0;
    battery_supply_uv = 1'b1;
    settle(10);
    chk("uv_off", 16'h0, 16'(out_on));
    battery_supply_uv = 1'b0;
    settle(10);
    chk("uv_reset", 16'h0, 16'(out_on));
    send(16, 32'hff00);
    wake = 1'b0;
    settle(10);
    chk("sleep", 16'h0, 16'(detect));
    wake = 1'b1;
    settle(10);
    send(16, 32'hff20);
    logic_supply_ok = 1'b0;
    settle(10);
    chk("supply_off", 16'h0, {out_on, detect});
    logic_supply_ok = 1'b1;
    settle(10);
  endtask : t_supply
  task automatic results;
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {resetn, battery_supply_uv, battery_supply_ov, drive_five, drive_six} = '0;
    {wake, logic_supply_ok} = 2'b11;
    {thermal, overcurrent, open_load} = '0;
    settle(2);
    resetn = 1'b1;
    settle(6);
    t_command();
    t_count();
    t_fault();
    t_supply();
    results();
  end
  // About 15 us of traffic is expected
  initial begin
    #60000;
    mismatches++;
    results();
  end
endmodule : octal_switch_spi_fault_control_tb_top
